/* File: src/hall_signal_processing_chain.sv */
// hall signal processing chain with wishbone register file
`timescale 1ns/10ps
`include "hall_chain_map.svh"
module hall_signal_processing_chain
  import hall_chain_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [15:0] i_hall_sample,
  input wire logic i_hall_over,
  input wire logic [7:0] i_temp_sample,
  output logic [11:0] o_dac_code,
  output logic o_dac_strobe
);
  // reset release through two flops
  logic rst_s1_r;
  logic rst_b_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r <= rst_s1_r;
    end
  end

  cfg_t cfg_r;             // programmed settings
  logic [11:0] raw_r;      // last limited result before interpolation
  logic ovf_seen_r;        // sticky fifo refusal flag

  // saturate a signed value to 12 bits
  function automatic logic [11:0] lim12(input logic signed [31:0] v);
    if (v < 0) begin
      lim12 = 12'h000;
    end else if (v > 32'sd4095) begin
      lim12 = `OUT_MAX;
    end else begin
      lim12 = v[11:0];
    end
  endfunction : lim12

  // wishbone slave: one wait state, ack one cycle
  logic wb_req;
  logic [3:0] wb_idx;
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_idx = i_wb_adr[5:2];
  logic stat_clr;
  assign stat_clr = wb_req && i_wb_we && (wb_idx == `ADR_STAT) && i_wb_sel[0];
  always_ff @(posedge i_mclk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      cfg_r.span <= `RST_SPAN;
      cfg_r.gain <= `RST_GAIN;
      cfg_r.offs <= `RST_OFFS;
      cfg_r.filt <= `RST_FILT;
      cfg_r.floor_lim <= `RST_FLOOR;
      cfg_r.ceil_lim <= `RST_CEIL;
      cfg_r.tc1 <= `RST_TC1;
      cfg_r.tc2 <= `RST_TC2;
      cfg_r.tref <= `RST_TREF;
    end else begin
      // ack pulses one cycle after the taking edge
      o_wb_ack <= wb_req;
      if (wb_req && i_wb_we) begin
        // low bytes only; fields above 16 bits do not exist
        case (wb_idx)
          `ADR_SPAN: if (i_wb_sel[0]) cfg_r.span <= i_wb_dat[1:0];
          `ADR_GAIN: begin
            if (i_wb_sel[0]) cfg_r.gain[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) cfg_r.gain[14:8] <= i_wb_dat[14:8];
          end
          `ADR_OFFS: begin
            if (i_wb_sel[0]) cfg_r.offs[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) cfg_r.offs[14:8] <= i_wb_dat[14:8];
          end
          `ADR_FILT: if (i_wb_sel[0]) cfg_r.filt <= i_wb_dat[2:0];
          `ADR_FLOOR: begin
            if (i_wb_sel[0]) cfg_r.floor_lim[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) cfg_r.floor_lim[11:8] <= i_wb_dat[11:8];
          end
          `ADR_CEIL: begin
            if (i_wb_sel[0]) cfg_r.ceil_lim[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) cfg_r.ceil_lim[11:8] <= i_wb_dat[11:8];
          end
          `ADR_TC1: begin
            if (i_wb_sel[0]) cfg_r.tc1[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) cfg_r.tc1[8] <= i_wb_dat[8];
          end
          `ADR_TC2: if (i_wb_sel[0]) cfg_r.tc2 <= i_wb_dat[7:0];
          `ADR_TREF: if (i_wb_sel[0]) cfg_r.tref <= i_wb_dat[2:0];
          default: begin
          end
        endcase
      end
      if (wb_req && !i_wb_we) begin
        // read mux; unmapped reads zero
        case (wb_idx)
          `ADR_SPAN: o_wb_dat <= {30'h0, cfg_r.span};
          `ADR_GAIN: o_wb_dat <= {17'h0, cfg_r.gain};
          `ADR_OFFS: o_wb_dat <= {17'h0, cfg_r.offs};
          `ADR_FILT: o_wb_dat <= {29'h0, cfg_r.filt};
          `ADR_FLOOR: o_wb_dat <= {20'h0, cfg_r.floor_lim};
          `ADR_CEIL: o_wb_dat <= {20'h0, cfg_r.ceil_lim};
          `ADR_TC1: o_wb_dat <= {23'h0, cfg_r.tc1};
          `ADR_TC2: o_wb_dat <= {24'h0, cfg_r.tc2};
          `ADR_TREF: o_wb_dat <= {29'h0, cfg_r.tref};
          `ADR_STAT: o_wb_dat <= {31'h0, ovf_seen_r};
          `ADR_OUT: o_wb_dat <= {20'h0, raw_r};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // rate enables from dividers
  logic [9:0] div_in_r;
  logic [5:0] div_out_r;
  logic tick_in;
  logic tick_out;
  assign tick_in = (div_in_r == 10'(`DIV_IN - 1));
  assign tick_out = (div_out_r == 6'(`DIV_OUT - 1));
  always_ff @(posedge i_mclk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      div_in_r <= 10'h000;
      div_out_r <= 6'h00;
    end else begin
      // each counter restarts after its terminal count
      div_in_r <= tick_in ? 10'h000 : div_in_r + 10'h001;
      div_out_r <= tick_out ? 6'h00 : div_out_r + 6'h01;
    end
  end

  // input low pass: one-pole, shift per setting, unity dc gain
  logic signed [23:0] lp_acc_r;   // state with 8 fractional bits
  logic signed [23:0] lp_in;
  logic [3:0] lp_sh;
  logic signed [15:0] lp_out;
  logic signed [24:0] lp_diff;    // one bit wider so a full-scale step cannot wrap
  assign lp_in = {i_hall_sample, 8'h00};
  // step toward the new sample, computed at full width
  assign lp_diff = 25'(lp_in) - 25'(lp_acc_r);
  always_comb begin
    case (cfg_r.filt)
      3'h0: lp_sh = 4'h7;
      3'h1: lp_sh = 4'h6;
      3'h2: lp_sh = 4'h5;
      3'h3: lp_sh = 4'h4;
      3'h4: lp_sh = 4'h3;
      3'h5: lp_sh = 4'h2;
      3'h6: lp_sh = 4'h1;
      default: lp_sh = 4'h0;
    endcase
  end
  always_ff @(posedge i_mclk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lp_acc_r <= 24'sh000000;
    end else if (tick_in) begin
      if (cfg_r.filt == 3'h7) begin
        lp_acc_r <= lp_in;
      end else begin
        lp_acc_r <= lp_acc_r + 24'(lp_diff >>> lp_sh);
      end
    end
  end
  // round by half a code: the residue left by the shift never drops a whole code
  assign lp_out = 16'((lp_acc_r + 24'sd128) >>> 8);

  // fifo between filter and compute stage
  sample_t fifo_in;
  sample_t fifo_out;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic lp_valid_r;
  always_ff @(posedge i_mclk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      lp_valid_r <= 1'b0;
      ovf_seen_r <= 1'b0;
    end else begin
      lp_valid_r <= tick_in;
      if (lp_valid_r && !fifo_wr_ready) begin
        ovf_seen_r <= 1'b1;   // set wins over clear
      end else if (stat_clr && i_wb_dat[0]) begin
        ovf_seen_r <= 1'b0;
      end
    end
  end
  assign fifo_in.hall = lp_out;
  assign fifo_in.range_bad = i_hall_over;
  sample_fifo #(.WIDTH(17), .DEPTH(16)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_b(rst_b_r),
    .i_wr_valid(lp_valid_r),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data(fifo_in),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready),
    .o_rd_data(fifo_out)
  );

  // compute sequencer: temperature, scale factor, output
  calc_st_t st_r;
  logic signed [31:0] tdiff_r;     // temperature minus reference, degrees
  logic signed [31:0] scale_r;     // gain times compensation, 2^-24 units
  logic signed [31:0] comp;
  logic signed [31:0] lin_t;
  logic signed [31:0] quad_t;
  logic signed [31:0] gain_v;
  logic signed [31:0] offs_v;
  logic signed [63:0] prod;
  logic signed [31:0] result;
  // operands held for the multiply sequence
  logic signed [15:0] fifo_hold_r; // sample held for multiply
  logic bad_hold_r;                // over-range flag of the held sample
  assign fifo_rd_ready = (st_r == ST_IDLE);
  // coefficient terms, scaled to 2^-24
  assign lin_t = tdiff_r * ($signed({23'h0, cfg_r.tc1}) - $signed({22'h0, `TC1_MID})) * 256;
  assign quad_t = tdiff_r * tdiff_r * ($signed({24'h0, cfg_r.tc2}) - $signed({23'h0, `TC2_MID})) * 2;
  assign comp = 32'sd16777216 + lin_t + quad_t;
  assign gain_v = $signed({17'h0, cfg_r.gain}) - $signed({16'h0, `CODE_MID});
  assign offs_v = $signed({17'h0, cfg_r.offs}) - $signed({16'h0, `CODE_MID});
  assign prod = 64'(scale_r) * 64'($signed(fifo_hold_r));
  // full scale 4096 codes: field sample times gain over 4096, plus offset
  assign result = 32'(prod >>> 24) + offs_v;
  always_ff @(posedge i_mclk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      st_r <= ST_IDLE;
      tdiff_r <= 32'sh0;
      scale_r <= 32'sh0;
      fifo_hold_r <= 16'sh0;
      bad_hold_r <= 1'b0;
      raw_r <= 12'h000;
    end else begin
      case (st_r)
        ST_IDLE: if (fifo_rd_valid) begin
          fifo_hold_r <= fifo_out.hall;
          bad_hold_r <= fifo_out.range_bad;
          st_r <= ST_TEMP;
        end
        ST_TEMP: begin
          // degrees above -48 minus the reference point
          tdiff_r <= $signed({24'h0, i_temp_sample}) - 32'sd48
                     - ($signed({29'h0, cfg_r.tref}) * 16 - 32'sd48);
          st_r <= ST_MULT;
        end
        ST_MULT: begin
          scale_r <= 32'((64'(gain_v) * 64'(comp)) >>> 12);
          st_r <= ST_PUSH;
        end
        ST_PUSH: begin
          if (bad_hold_r) begin
            // field outside span: force clamp by sign
            raw_r <= fifo_hold_r[15] ? cfg_r.floor_lim : cfg_r.ceil_lim;
          end else if (lim12(result) < cfg_r.floor_lim) begin
            raw_r <= cfg_r.floor_lim;
          end else if (lim12(result) > cfg_r.ceil_lim) begin
            raw_r <= cfg_r.ceil_lim;
          end else begin
            raw_r <= lim12(result);
          end
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // interpolation: first-order glide toward raw, one sixteenth of the remaining gap per update at 256 kHz, never bypassed
  logic signed [16:0] interp_r;   // 12.4 fixed point
  always_ff @(posedge i_mclk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      interp_r <= 17'sh0;
      o_dac_code <= 12'h000;
      o_dac_strobe <= 1'b0;
    end else begin
      o_dac_strobe <= tick_out;
      if (tick_out) begin
        interp_r <= interp_r + (($signed({1'b0, raw_r, 4'h0}) - interp_r) >>> 4);
        // the code shown lags the ramp by one update
        o_dac_code <= interp_r[15:4];
      end
    end
  end

  // update spacing of the output and the input stage
  a_dac_rate: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    o_dac_strobe |=> !o_dac_strobe [*8]) else $error("dac strobe too fast");
  a_in_rate: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    tick_in |=> !tick_in [*8]) else $error("input tick too fast");
  a_dac_hold: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    !tick_out |=> $stable(o_dac_code)) else $error("dac code moved between updates");

  // clamp window, only meaningful with the ceiling at or above the floor
  logic clamp_ok;
  assign clamp_ok = (cfg_r.floor_lim <= cfg_r.ceil_lim);
  a_clamp_band: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (st_r == ST_PUSH && !bad_hold_r && clamp_ok) |=>
    (raw_r >= $past(cfg_r.floor_lim) && raw_r <= $past(cfg_r.ceil_lim)))
    else $error("clamp band");
  a_over_clamp: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (st_r == ST_PUSH && bad_hold_r && !fifo_hold_r[15]) |=> raw_r == $past(cfg_r.ceil_lim))
    else $error("over-range not clamped high");
  a_under_clamp: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (st_r == ST_PUSH && bad_hold_r && fifo_hold_r[15]) |=> raw_r == $past(cfg_r.floor_lim))
    else $error("over-range not clamped low");

  // limiter end points saturate instead of wrapping
  a_sat_high: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (st_r == ST_PUSH && !bad_hold_r && clamp_ok && result > 32'sd4095) |=>
    raw_r == $past(cfg_r.ceil_lim)) else $error("limiter did not saturate high");
  a_sat_low: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (st_r == ST_PUSH && !bad_hold_r && clamp_ok && result < 32'sd0) |=>
    raw_r == $past(cfg_r.floor_lim)) else $error("limiter did not saturate low");

  // transparent bypass and fixed compute order
  a_bypass_pass: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (tick_in && cfg_r.filt == 3'h7) |=> lp_out == $past(i_hall_sample))
    else $error("bypass not transparent");
  a_seq_order: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (st_r == ST_IDLE && fifo_rd_valid) |=> st_r == ST_TEMP ##1 st_r == ST_MULT
    ##1 st_r == ST_PUSH ##1 st_r == ST_IDLE) else $error("compute order");

  // bus answers exactly one cycle after the taking edge
  a_wb_ack: assert property (@(posedge i_mclk) disable iff (!rst_b_r)
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack timing");

  // main scenarios
  c_clamp_hi: cover property (@(posedge i_mclk) disable iff (!rst_b_r)
    st_r == ST_PUSH && bad_hold_r);
  c_bypass: cover property (@(posedge i_mclk) disable iff (!rst_b_r)
    tick_in && cfg_r.filt == 3'h7);
  c_filtered: cover property (@(posedge i_mclk) disable iff (!rst_b_r)
    tick_in && cfg_r.filt == 3'h0);
  c_saturate: cover property (@(posedge i_mclk) disable iff (!rst_b_r)
    st_r == ST_PUSH && !bad_hold_r && result > 32'sd4095);
endmodule : hall_signal_processing_chain

/* File: common/hall_chain_map.svh */
// constant map of the hall signal processing chain
`ifndef HALL_CHAIN_MAP_SVH
`define HALL_CHAIN_MAP_SVH
`define ADR_SPAN 4'h0
`define ADR_GAIN 4'h1
`define ADR_OFFS 4'h2
`define ADR_FILT 4'h3
`define ADR_FLOOR 4'h4
`define ADR_CEIL 4'h5
`define ADR_TC1 4'h6
`define ADR_TC2 4'h7
`define ADR_TREF 4'h8
`define ADR_STAT 4'h9
`define ADR_OUT 4'ha
`define RST_SPAN 2'h1
`define RST_GAIN 15'h5000
`define RST_OFFS 15'h4000
`define RST_FILT 3'h7
`define RST_FLOOR 12'h000
`define RST_CEIL 12'hfff
`define RST_TC1 9'h0a0
`define RST_TC2 8'h80
`define RST_TREF 3'h3
`define CODE_MID 16'h4000
`define TC1_MID 10'h0a0
`define TC2_MID 9'h080
`define CLK_HZ 10000000
`define RATE_IN_HZ 16000
`define RATE_OUT_HZ 256000
`define DIV_IN ((`CLK_HZ) / (`RATE_IN_HZ))
`define DIV_OUT ((`CLK_HZ) / (`RATE_OUT_HZ))
`define OUT_MAX 12'hfff
`endif

/* File: common/hall_chain_pkg.sv */
// types of the hall signal processing chain
package hall_chain_pkg;
  typedef struct packed {
    logic [1:0] span;
    logic [14:0] gain;
    logic [14:0] offs;
    logic [2:0] filt;
    logic [11:0] floor_lim;
    logic [11:0] ceil_lim;
    logic [8:0] tc1;
    logic [7:0] tc2;
    logic [2:0] tref;
  } cfg_t;
  typedef struct packed {
    logic [15:0] hall;
    logic range_bad;
  } sample_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TEMP = 2'b01,
    ST_MULT = 2'b11,
    ST_PUSH = 2'b10
  } calc_st_t;
endpackage : hall_chain_pkg

/* File: src/sample_fifo.sv */
// parameterised fifo carrying filtered samples to the compute stage
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];        // storage
  logic [AW:0] wp_r;                    // write pointer, extra wrap bit
  logic [AW:0] rp_r;                    // read pointer
  logic push;
  logic pop;
  logic full;
  logic empty;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign o_wr_ready = !full;
  assign push = i_wr_valid && !full;
  // read data register holds head; valid while loaded
  logic loaded_r;
  assign o_rd_valid = loaded_r;
  assign pop = !empty && (!loaded_r || i_rd_ready);
  // storage write
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_wr_data;
    end
  end
  // pointers and output register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      loaded_r <= 1'b0;
      o_rd_data <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
        o_rd_data <= mem[rp_r[AW-1:0]];
        loaded_r <= 1'b1;
      end else if (i_rd_ready) begin
        loaded_r <= 1'b0;
      end
    end
  end
  // occupancy never exceeds the depth
  a_fifo_depth: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wp_r - rp_r) <= (AW+1)'(DEPTH)) else $error("fifo occupancy beyond depth");
endmodule : sample_fifo

/* File: bench/adc_reader_model.sv */
// microcontroller adc model sampling the dac output at each update
`timescale 1ns/10ps
module adc_reader_model (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [11:0] i_dac_code,
  input wire logic i_dac_strobe,
  output logic [11:0] o_code,
  output logic o_got,
  output logic [15:0] o_gap
);
  logic [15:0] run_r; // clocks since the last update
  // latch the code and the update spacing on each strobe
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_code <= 12'h000;
      o_got <= 1'b0;
      o_gap <= 16'h0000;
      run_r <= 16'h0000;
    end else begin
      o_got <= i_dac_strobe;
      run_r <= i_dac_strobe ? 16'h0001 : run_r + 16'h0001;
      // new conversion result
      if (i_dac_strobe) begin
        o_code <= i_dac_code;
        o_gap <= run_r;
      end
    end
  end
endmodule : adc_reader_model

/* File: bench/tb.sv */
// self-checking bench of the hall signal processing chain
`timescale 1ns/10ps
`include "hall_chain_map.svh"
module tb;
  typedef struct {string name; logic [31:0] exp; int tol;} note_t;
  logic i_mclk, i_rst_b, cyc, stb, we, ack, over, dstb, pgot;
  logic [5:0] adr; // byte address
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [15:0] hall, pgap;
  logic [7:0] temp;
  logic [11:0] dac, pcode;
  note_t rq[$]; // pending read notes
  note_t dq[$]; // pending dac notes
  int miscompares, checked;
  logic [31:0] rstv[10] = '{`RST_SPAN, `RST_GAIN, `RST_OFFS, `RST_FILT, `RST_FLOOR,
    `RST_CEIL, `RST_TC1, `RST_TC2, `RST_TREF, 32'h0};
  int wid[9] = '{2, 15, 15, 3, 12, 12, 9, 8, 3};
  logic [31:0] v;

  hall_signal_processing_chain dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_hall_sample(hall), .i_hall_over(over),
    .i_temp_sample(temp), .o_dac_code(dac), .o_dac_strobe(dstb));
  adc_reader_model far (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_dac_code(dac),
    .i_dac_strobe(dstb), .o_code(pcode), .o_got(pgot), .o_gap(pgap));

  // 10 mhz clock
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // compare with a tolerance for rounded arithmetic
  task automatic note(input note_t n, input logic [31:0] seen);
    int d;
    d = int'(seen) - int'(n.exp);
    if (^seen !== 1'bx && d <= n.tol && d >= -n.tol) seen = n.exp;
    check(n.name, seen, n.exp);
  endtask : note

  // result watcher: oldest note against each answer
  always @(posedge i_mclk) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) note(rq.pop_front(), rdat);
    if (pgot === 1'b1 && dq.size() > 0) note(dq.pop_front(), {20'h0, pcode});
  end

  // one classic wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h3;
    adr <= {idx, 2'b00};
    wdat <= d;
    do @(posedge i_mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input string nm, input logic [3:0] idx, input logic [31:0] e, input int t);
    rq.push_back('{nm, e, t});
    bus(1'b0, idx, 32'h0);
  endtask : rd

  // program the datapath, apply a sample and read the limited result
  task automatic run(input string nm, input logic [14:0] g, input logic [14:0] o,
      input logic [15:0] h, input logic [7:0] t, input logic [2:0] tr, input logic [8:0] t1,
      input logic [7:0] t2, input int n, input logic [31:0] e, input int tol);
    wr(`ADR_GAIN, {17'h0, g});
    wr(`ADR_OFFS, {17'h0, o});
    wr(`ADR_TREF, {29'h0, tr});
    wr(`ADR_TC1, {23'h0, t1});
    wr(`ADR_TC2, {24'h0, t2});
    hall <= h;
    temp <= t;
    repeat (n * `DIV_IN + 40) @(posedge i_mclk);
    rd(nm, `ADR_OUT, e, tol);
    $display("test %s done", nm);
  endtask : run

  // over-range or in-range sample seen at the dac
  task automatic clampc(input string nm, input logic [15:0] h, input logic ov, input int e);
    hall <= h;
    over <= ov;
    repeat (10 * `DIV_IN) @(posedge i_mclk); // ramp settles within one code
    dq.push_back('{nm, e, 16});
    repeat (100) @(posedge i_mclk);
    $display("test %s done", nm);
  endtask : clampc

  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // watchdog
  initial begin
    repeat (90000) @(posedge i_mclk);
    miscompares++;
    $display("watchdog expired");
    results();
  end

  // main sequence
  initial begin
    {cyc, stb, we, over, i_rst_b} = 5'h0;
    adr = 6'h00;
    sel = 4'h3;
    wdat = 32'h0;
    hall = 16'h0000;
    temp = 8'd48;
    v = $urandom(23);
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_mclk);
    for (int i = 0; i < 10; i++) rd("reset value", i[3:0], rstv[i], 0);
    for (int i = 0; i < 9; i++) begin
      v = $urandom & ((32'h1 << wid[i]) - 32'h1);
      wr(i[3:0], v);
      rd("register rw", i[3:0], v, 0);
    end
    rd("unmapped read", 4'hb, 32'h0, 0);
    wr(4'hc, 32'hffff);
    rd("unmapped write", 4'hc, 32'h0, 0);
    $display("test registers done");
    wr(`ADR_SPAN, 32'h1);
    wr(`ADR_FILT, 32'h7);
    wr(`ADR_FLOOR, 32'h0);
    wr(`ADR_CEIL, 32'hfff);
    run("gain one", 15'h5000, 15'h4800, 16'd1000, 8'd48, 3'd3, 9'h0a0, 8'h80, 2, 3048, 0);
    run("gain neg", 15'h3000, 15'h4800, 16'd1000, 8'd48, 3'd3, 9'h0a0, 8'h80, 2, 1048, 0);
    run("gain half", 15'h4800, 15'h4800, 16'd1000, 8'd48, 3'd3, 9'h0a0, 8'h80, 2, 2548, 0);
    run("lim high", 15'h5000, 15'h4800, 16'd3000, 8'd48, 3'd3, 9'h0a0, 8'h80, 2, 4095, 0);
    run("lim low", 15'h5000, 15'h4000, 16'hfe0c, 8'd48, 3'd3, 9'h0a0, 8'h80, 2, 0, 0);
    run("tref", 15'h5000, 15'h4000, 16'd1000, 8'd80, 3'd5, 9'h1ff, 8'hff, 2, 1000, 0);
    run("linear", 15'h5000, 15'h4000, 16'd1000, 8'd148, 3'd3, 9'h1ff, 8'h80, 2, 1536, 4);
    run("square", 15'h5000, 15'h4000, 16'd1000, 8'd148, 3'd3, 9'h0a0, 8'hff, 2, 1151, 4);
    run("both", 15'h4800, 15'h4000, 16'd1000, 8'd148, 3'd3, 9'h1ff, 8'hff, 2, 843, 4);
    run("cold", 15'h5000, 15'h4000, 16'd1000, 8'd8, 3'd3, 9'h1ff, 8'h80, 2, 786, 4);
    wr(`ADR_FILT, 32'h6);
    run("filter dc", 15'h5000, 15'h4000, 16'd1500, 8'd48, 3'd3, 9'h0a0, 8'h80, 24, 1500, 0);
    wr(`ADR_FILT, 32'h7);
    v = $urandom_range(1500);
    run("random", 15'h5000, 15'h4800, v[15:0], 8'd48, 3'd3, 9'h0a0, 8'h80, 2, v + 2048, 0);
    wr(`ADR_FLOOR, 32'h200);
    wr(`ADR_CEIL, 32'hc00);
    clampc("clamp high", 16'd1000, 1'b1, 32'hc00);
    clampc("clamp low", 16'hfc18, 1'b1, 32'h200);
    clampc("in range", 16'd1000, 1'b0, 3048);
    check("dac gap", {16'h0, pgap}, `DIV_OUT);
    repeat (2) @(posedge i_mclk);
    results();
  end
endmodule : tb
